//--- src/rxm_dev.sv
/*
  receiver end: mode decode, oscillator start, synthesizer and signal path
  start-up sequencing, rate and demod switching, gated data output and the
  microcontroller clock output.
  assumes control pins come from logic on pclk; the radio inputs are
  asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module rxm_dev
  import rxm_pkg::*;
#(
  parameter bit VARIANT_315 = 1'b0
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  rxm_if.dev              link,
  input  wire logic [1:0] rf_input,
  output logic            rx_ready,
  output logic            osc_ok
);
  logic [1:0]  rf_s1_r;
  logic [1:0]  rf_s2_r;
  logic [5:0]  div_r;
  logic [11:0] cnt_r;
  logic [11:0] cnt_nxt;
  logic [1:0]  range_r;
  logic [1:0]  range_nxt;
  logic        ask_r;
  logic        ask_nxt;
  logic        load;
  logic        data_r;
  logic        clk_r;
  logic [3:0]  clk_cnt_r;
  rxm_state_t  state_r;
  rxm_state_t  state_nxt;

  // pin decode
  wire        osc_on    = link.enable | link.rx_activate;
  wire        active    = link.enable & link.rx_activate;
  wire [1:0]  range_pin = {link.rate_range_sel_hi,
                           link.rate_range_sel_lo};
  wire        ask_pin   = link.demod_type_select;
  wire        tick      = (div_r == TICK_LAST);
  wire        expire    = tick & (cnt_r == 12'h001);
  wire        range_chg = (range_pin != range_r);
  wire        ask_chg   = (ask_pin != ask_r);
  wire [11:0] pll_us    = VARIANT_315 ? PLL_315_US : PLL_433_US;
  wire [11:0] sig_us    = rxm_sig_us(VARIANT_315, range_pin);
  // demodulated level: carrier for ask, upper tone for fsk
  wire        demod_bit = ask_r ? rf_s2_r[0] : rf_s2_r[1];

  // radio inputs are asynchronous: two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_s1_r <= 2'h0;
      rf_s2_r <= 2'h0;
    end else begin
      rf_s1_r <= rf_input;
      rf_s2_r <= rf_s1_r;
    end
  end

  // microsecond divider; restarted on each phase load so that a phase
  // lasts exactly its count, never a partial tick short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 6'h00;
    end else if (load || tick) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    range_nxt = range_r;
    ask_nxt   = ask_r;
    load      = 1'b0;
    if (tick && cnt_r != 12'h000) begin
      cnt_nxt = cnt_r - 12'h001;
    end
    unique case (state_r)
      ST_OFF: begin
        if (osc_on) begin
          state_nxt = ST_XTO;
          cnt_nxt   = XTO_START_US;
          load      = 1'b1;
        end
      end
      ST_XTO: begin
        if (expire) begin
          state_nxt = ST_STBY;
        end
      end
      ST_STBY: begin
        if (active) begin
          state_nxt = ST_PLL;
          cnt_nxt   = pll_us;
          load      = 1'b1;
        end
      end
      ST_PLL: begin
        if (expire) begin
          // path start-up only after lock, timed by range at that moment
          state_nxt = ST_SIG;
          cnt_nxt   = sig_us;
          range_nxt = range_pin;
          ask_nxt   = ask_pin;
          load      = 1'b1;
        end
      end
      ST_SIG: begin
        if (range_chg || ask_chg) begin
          cnt_nxt   = sig_us;
          range_nxt = range_pin;
          ask_nxt   = ask_pin;
          load      = 1'b1;
        end else if (expire) begin
          state_nxt = ST_READY;
        end
      end
      ST_RATE, ST_READY: begin
        if (ask_chg) begin
          // demod swap restarts the path for the new range
          state_nxt = ST_SIG;
          cnt_nxt   = sig_us;
          range_nxt = range_pin;
          ask_nxt   = ask_pin;
          load      = 1'b1;
        end else if (range_chg) begin
          state_nxt = ST_RATE;
          cnt_nxt   = RATE_SWAP_US;
          range_nxt = range_pin;
          load      = 1'b1;
        end else if (state_r == ST_RATE && expire) begin
          state_nxt = ST_READY;
        end
      end
    endcase
    // leaving active drops straight back; both pins low stops all
    if (!osc_on) begin
      state_nxt = ST_OFF;
      cnt_nxt   = 12'h000;
    end else if (!active && state_r inside {ST_PLL, ST_SIG,
                                            ST_RATE, ST_READY}) begin
      state_nxt = ST_STBY;
      cnt_nxt   = 12'h000;
    end
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OFF;
      cnt_r   <= 12'h000;
      range_r <= 2'h0;
      ask_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      range_r <= range_nxt;
      ask_r   <= ask_nxt;
    end
  end

  // data gate: low through every settling interval; no gap timeout, so
  // long ask pauses and any line code pass untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= 1'b0;
    end else if (state_r == ST_READY) begin
      data_r <= demod_bit;
    end else begin
      data_r <= 1'b0;
    end
  end

  // microcontroller clock: pclk divided by 3, 6 or 12, only while the
  // oscillator is up; divide by 3 is high one pclk cycle in three, 6 and 12 give half
  wire       clk_ok  = (state_r != ST_OFF) && (state_r != ST_XTO);
  wire [3:0] clk_div = (link.clk_out_sel == 2'h1) ? CLKO_DIV_1 :
                       (link.clk_out_sel == 2'h2) ? CLKO_DIV_2 : CLKO_DIV_3;
  wire       clk_run = clk_ok && (link.clk_out_sel != 2'h0);
  wire       clk_end = (clk_cnt_r >= clk_div - 4'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cnt_r <= 4'h0;
      clk_r     <= 1'b0;
    end else if (!clk_run) begin
      clk_cnt_r <= 4'h0;
      clk_r     <= 1'b0;
    end else begin
      clk_cnt_r <= clk_end ? 4'h0 : clk_cnt_r + 4'h1;
      clk_r     <= clk_end ? 1'b1 : (clk_cnt_r < (clk_div >> 1) - 4'h1);
    end
  end

  assign link.data_out = data_r;
  assign link.clk_out  = clk_r;
  assign rx_ready      = (state_r == ST_READY);
  assign osc_ok        = clk_ok;
endmodule // rxm_dev
`default_nettype wire

//--- src/rxm_pkg.sv
/*
  shared constants, types and lookup functions for the receiver mode and
  start-up sequencer and its controller.
  assumes one 40 MHz clock (pclk) on both ends.
*/
// Operation
// - both pins low: oscillator off, deaf
// - enable only: oscillator on, path off
// - both high: active, data passed on
// - synthesizer phase first, then signal path
// - synthesizer phase 261/269 us per variant
// - 433 MHz path phase 1096/644/417/304 us
// - 315 MHz path phase 1132/665/431/324 us
// - data follows upper freq or carrier
// - two select pins pick range 0-3
// - same-demod range change settles in 100 us
// - demod plus range change: full path start-up
// - edge spacing at least 200/100/50 us
// - fsk range 3 minimum spacing is 25 us
// - start-up spacing below 500/250/125/62.5 us
// - no signal at start-up gives noise
// - ask gaps up to 52 ms tolerated
// - software picks lowest covering range
// - any line code passes transparently
// - demod select 1 is ask, 0 fsk
// - re-settling uses newly selected range
`default_nettype none
package rxm_pkg;
  // clock and the 1 us timing tick
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int TICK_NS      = 1000;
  localparam int TICK_CYC     = (CLK_FREQ_KHZ * TICK_NS + 999999) / 1000000;
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYC - 1);

  // phase times in microseconds; one tick per microsecond
  localparam logic [11:0] XTO_START_US  = 12'h00a;
  localparam logic [11:0] PLL_433_US    = 12'h105;
  localparam logic [11:0] PLL_315_US    = 12'h10d;
  localparam logic [11:0] RATE_SWAP_US  = 12'h064;
  localparam logic [11:0] SIG_433_R0_US = 12'h448;
  localparam logic [11:0] SIG_433_R1_US = 12'h284;
  localparam logic [11:0] SIG_433_R2_US = 12'h1a1;
  localparam logic [11:0] SIG_433_R3_US = 12'h130;
  localparam logic [11:0] SIG_315_R0_US = 12'h46c;
  localparam logic [11:0] SIG_315_R1_US = 12'h299;
  localparam logic [11:0] SIG_315_R2_US = 12'h1af;
  localparam logic [11:0] SIG_315_R3_US = 12'h144;

  // microcontroller clock divide ratios for select codes 01, 10 and 11
  localparam logic [3:0]  CLKO_DIV_1 = 4'h3;
  localparam logic [3:0]  CLKO_DIV_2 = 4'h6;
  localparam logic [3:0]  CLKO_DIV_3 = 4'hc;

  // edge spacing limits in microseconds
  localparam logic [15:0] MIN_R0_US  = 16'h00c8;
  localparam logic [15:0] MIN_R1_US  = 16'h0064;
  localparam logic [15:0] MIN_R2_US  = 16'h0032;
  localparam logic [15:0] MIN_FSK3_US = 16'h0019;
  localparam logic [15:0] MAX_R0_US  = 16'h01f4;
  localparam logic [15:0] MAX_R1_US  = 16'h00fa;
  localparam logic [15:0] MAX_R2_US  = 16'h007d;
  localparam logic [15:0] MAX_R3_US  = 16'h003e;

  // controller registers (byte offsets)
  localparam logic [7:0]  CTRL_OFS  = 8'h00;
  localparam logic [7:0]  STAT_OFS  = 8'h04;
  localparam logic [7:0]  SPACE_OFS = 8'h08;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_RX_BIT   = 1;
  localparam int CTRL_ASK_BIT  = 2;
  localparam int CTRL_RATE_LSB = 3;
  localparam int CTRL_CLK_LSB  = 5;
  localparam int CTRL_WIDTH    = 7;
  localparam logic [6:0]  CTRL_RST  = 7'h00;
  localparam int STAT_DATA_BIT  = 0;
  localparam int STAT_SHORT_BIT = 1;
  localparam int STAT_LONG_BIT  = 2;
  localparam int STAT_CLK_BIT   = 3;

  typedef enum logic [2:0] {
    ST_OFF, ST_XTO, ST_STBY, ST_PLL, ST_SIG, ST_RATE, ST_READY
  } rxm_state_t;

  function automatic logic [11:0] rxm_sig_us(input logic v315,
                                             input logic [1:0] code);
    logic [11:0] t;
    t = 12'h000;
    unique case (code)
      2'h0: t = v315 ? SIG_315_R0_US : SIG_433_R0_US;
      2'h1: t = v315 ? SIG_315_R1_US : SIG_433_R1_US;
      2'h2: t = v315 ? SIG_315_R2_US : SIG_433_R2_US;
      2'h3: t = v315 ? SIG_315_R3_US : SIG_433_R3_US;
    endcase
    return t;
  endfunction

  function automatic logic [15:0] rxm_min_us(input logic ask,
                                             input logic [1:0] code);
    logic [15:0] t;
    t = 16'h0000;
    unique case (code)
      2'h0: t = MIN_R0_US;
      2'h1: t = MIN_R1_US;
      2'h2: t = MIN_R2_US;
      2'h3: t = ask ? MIN_R2_US : MIN_FSK3_US;
    endcase
    return t;
  endfunction

  function automatic logic [15:0] rxm_max_us(input logic [1:0] code);
    logic [15:0] t;
    t = 16'h0000;
    unique case (code)
      2'h0: t = MAX_R0_US;
      2'h1: t = MAX_R1_US;
      2'h2: t = MAX_R2_US;
      2'h3: t = MAX_R3_US;
    endcase
    return t;
  endfunction
endpackage
`default_nettype wire

//--- src/rxm_if.sv
/*
  pin bundle between the receiver and its controller.
  assumes both ends run on the same pclk; no clocking block.
*/
`timescale 1ns/1ps
`default_nettype none
interface rxm_if;
  logic       enable;
  logic       rx_activate;
  logic       demod_type_select;
  logic       rate_range_sel_lo;
  logic       rate_range_sel_hi;
  logic [1:0] clk_out_sel;
  logic       data_out;
  logic       clk_out;

  modport dev (input  enable, rx_activate, demod_type_select,
                      rate_range_sel_lo, rate_range_sel_hi, clk_out_sel,
               output data_out, clk_out);
  modport ctl (output enable, rx_activate, demod_type_select,
                      rate_range_sel_lo, rate_range_sel_hi, clk_out_sel,
               input  data_out, clk_out);
endinterface
`default_nettype wire

//--- src/rxm_ctl.sv
/*
  controller end: apb slave with a control register that drives the
  receiver pins, a status register, and an edge spacing monitor on the
  received data line.
  assumes the receiver runs on the same pclk; zero-wait apb.
*/
`timescale 1ns/1ps
`default_nettype none
module rxm_ctl
  import rxm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  rxm_if.ctl               link
);
  logic [6:0]  ctrl_r;
  logic        short_r;
  logic        long_r;
  logic        data_d_r;
  logic        seen_r;
  logic [5:0]  div_r;
  logic [15:0] gap_r;
  logic [15:0] space_r;

  // apb decode; unmapped offsets answer with an error and zero data
  wire access  = psel & penable;
  wire hit_ctl = (paddr == CTRL_OFS);
  wire hit_st  = (paddr == STAT_OFS);
  wire hit_sp  = (paddr == SPACE_OFS);
  wire mapped  = hit_ctl | hit_st | hit_sp;
  wire wr_ctl  = access & pwrite & hit_ctl;
  wire wr_st   = access & pwrite & hit_st;
  wire [1:0] range_now = ctrl_r[CTRL_RATE_LSB +: 2];
  wire       ask_now   = ctrl_r[CTRL_ASK_BIT];

  // edge monitor: spacing in microseconds, saturating
  wire tick     = (div_r == TICK_LAST);
  wire edge_hit = (link.data_out != data_d_r);
  wire too_short = edge_hit & seen_r &
                   (gap_r < rxm_min_us(ask_now, range_now));
  wire too_long  = edge_hit & seen_r &
                   (gap_r > rxm_max_us(range_now));

  wire [31:0] st_word = {28'h0000000, link.clk_out, long_r, short_r,
                         link.data_out};
  wire [31:0] rd_word = hit_ctl ? {25'h0, ctrl_r} :
                        hit_st  ? st_word :
                        hit_sp  ? {16'h0000, space_r} : 32'h00000000;

  // control register: software chooses mode, demod, range, clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctl) begin
      ctrl_r <= pwdata[CTRL_WIDTH-1:0];
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_r <= 1'b0;
      long_r  <= 1'b0;
    end else begin
      short_r <= too_short | (short_r & ~(wr_st & pwdata[STAT_SHORT_BIT]));
      long_r  <= too_long  | (long_r  & ~(wr_st & pwdata[STAT_LONG_BIT]));
    end
  end

  // spacing counter and last measured spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r    <= 6'h00;
      gap_r    <= 16'h0000;
      space_r  <= 16'h0000;
      data_d_r <= 1'b0;
      seen_r   <= 1'b0;
    end else begin
      div_r    <= (tick || edge_hit) ? 6'h00 : div_r + 6'h01;
      data_d_r <= link.data_out;
      if (edge_hit) begin
        space_r <= gap_r;
        gap_r   <= 16'h0000;
        seen_r  <= 1'b1;
      end else if (tick && gap_r != 16'hffff) begin
        gap_r   <= gap_r + 16'h0001;
      end
    end
  end

  // read data is registered at the access cycle's edge by the master
  always_comb begin
    prdata  = (access && !pwrite) ? rd_word : 32'h00000000;
    pready  = 1'b1;
    pslverr = access & ~mapped;
  end

  assign link.enable            = ctrl_r[CTRL_EN_BIT];
  assign link.rx_activate       = ctrl_r[CTRL_RX_BIT];
  assign link.demod_type_select = ctrl_r[CTRL_ASK_BIT];
  assign link.rate_range_sel_lo = ctrl_r[CTRL_RATE_LSB];
  assign link.rate_range_sel_hi = ctrl_r[CTRL_RATE_LSB+1];
  assign link.clk_out_sel       = ctrl_r[CTRL_CLK_LSB +: 2];
endmodule // rxm_ctl
`default_nettype wire

//--- tb/rxm_pins_sva.sv
/*
  assertions on the pin bundle between controller and receiver.
  assumes one pclk domain and the 433.92 MHz receiver timing.
*/
`timescale 1ns/1ps
`default_nettype none
module rxm_pins_sva
  import rxm_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       enable,
  input wire logic       rx_activate,
  input wire logic       demod_type_select,
  input wire logic       rate_range_sel_lo,
  input wire logic       rate_range_sel_hi,
  input wire logic [1:0] clk_out_sel,
  input wire logic       data_out,
  input wire logic       clk_out,
  input wire logic [1:0] rf_input,
  input wire logic       rx_ready,
  input wire logic       osc_ok
);
  logic [15:0] on_r;
  logic [15:0] act_r;
  wire logic   on_w  = enable | rx_activate;
  wire logic   act_w = enable & rx_activate;

  // run lengths of powered and active pins; saturate so long runs stay big
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_r  <= 16'h0000;
      act_r <= 16'h0000;
    end else begin
      on_r  <= on_w ? on_r + 16'(on_r != 16'hffff) : 16'h0000;
      act_r <= act_w ? act_r + 16'(act_r != 16'hffff) : 16'h0000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_quiet: assert property ((!on_w) [*5] |->
    !clk_out && !osc_ok && !data_out) else $error("off state not quiet");
  a_stby_deaf: assert property ((!act_w) [*3] |->
    !rx_ready && !data_out) else $error("standby not deaf");
  a_osc_start: assert property ($rose(osc_ok) |->
    on_r inside {[16'd396:16'd406]}) else $error("osc start time off");
  a_clk_off: assert property ((clk_out_sel == 2'h0 || !osc_ok) [*4]
    |-> !clk_out) else $error("clock output not off");
  a_ready_pins: assert property (rx_ready |-> $past(act_w))
    else $error("ready without both pins");
  a_start_min: assert property ($rose(rx_ready) |->
    act_r >= 16'd22590) else $error("ready before start-up phases");
  a_data_follow: assert property (rx_ready && $past(rx_ready, 3) &&
    $stable(demod_type_select) |->
    data_out == (demod_type_select ? $past(rf_input[0], 3)
                                   : $past(rf_input[1], 3)))
    else $error("data not following selected demod");
  a_data_gated: assert property ((!rx_ready) [*2] |-> !data_out)
    else $error("data not held low");
  a_swap_drop: assert property (rx_ready && act_w &&
    $stable(demod_type_select) &&
    !$stable({rate_range_sel_hi, rate_range_sel_lo})
    |-> ##1 (!rx_ready) [*8]) else $error("range change kept ready");

  c_ready: cover property ($rose(rx_ready));
  c_data: cover property (rx_ready && $rose(data_out));
  c_osc: cover property ($rose(osc_ok));
endmodule // rxm_pins_sva
`default_nettype wire

//--- tb/rx_mode_startup_and_rate_control_tb_top.sv
/*
  bench: controller and 433.92 MHz receiver on one pin bundle, a 315 MHz
  receiver on a copy of the pins, apb master tasks.
  assumes package, bundle, both ends and the checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_mode_startup_and_rate_control_tb_top
  import rxm_pkg::*;
;
  typedef struct {
    logic [6:0] ctrl;
    logic       osc;
    int         clks;
  } rxm_row_t;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  rf;
  logic        rdy_a, rdy_b, osc_a, osc_b, err;
  int          n_fail = 0;
  int          num_checks = 0;
  int          clk_n = 0;
  int          ta, tb;
  rxm_row_t    rows [5] = '{'{7'h1c, 1'b0, 0}, '{7'h01, 1'b1, 0},
    '{7'h22, 1'b1, 16}, '{7'h4d, 1'b1, 8}, '{7'h71, 1'b1, 4}};

  rxm_if u_if ();
  rxm_if u_if2 ();
  wire logic [6:0] pins = {u_if.clk_out_sel, u_if.rate_range_sel_hi,
    u_if.rate_range_sel_lo, u_if.demod_type_select, u_if.rx_activate,
    u_if.enable};

  // the 315 MHz receiver sees the same pins as the first one
  assign u_if2.enable            = u_if.enable;
  assign u_if2.rx_activate       = u_if.rx_activate;
  assign u_if2.demod_type_select = u_if.demod_type_select;
  assign u_if2.rate_range_sel_lo = u_if.rate_range_sel_lo;
  assign u_if2.rate_range_sel_hi = u_if.rate_range_sel_hi;
  assign u_if2.clk_out_sel       = u_if.clk_out_sel;

  rxm_ctl u_rxm_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_if.ctl));
  rxm_dev #(.VARIANT_315(1'b0)) u_rxm_dev (.pclk(pclk), .presetn(presetn),
    .link(u_if.dev), .rf_input(rf), .rx_ready(rdy_a), .osc_ok(osc_a));
  rxm_dev #(.VARIANT_315(1'b1)) u_rxm_dev_315 (.pclk(pclk),
    .presetn(presetn), .link(u_if2.dev), .rf_input(rf), .rx_ready(rdy_b),
    .osc_ok(osc_b));
  rxm_pins_sva u_sva (.pclk(pclk), .presetn(presetn),
    .enable(u_if.enable), .rx_activate(u_if.rx_activate),
    .demod_type_select(u_if.demod_type_select),
    .rate_range_sel_lo(u_if.rate_range_sel_lo),
    .rate_range_sel_hi(u_if.rate_range_sel_hi),
    .clk_out_sel(u_if.clk_out_sel), .data_out(u_if.data_out),
    .clk_out(u_if.clk_out), .rf_input(rf), .rx_ready(rdy_a),
    .osc_ok(osc_a));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // clock output activity, counted in rising edges
  always @(posedge u_if.clk_out) clk_n++;

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] near(input int t, input int e);
    return 32'(t >= e - 6 && t <= e + 6);
  endfunction

  // new pin settings, then the data gate and the time back to ready;
  // a missing ready ends the run rather than hanging it
  task automatic change(input logic [6:0] c, input int e_a, input int e_b);
    apb(1'b1, CTRL_OFS, {25'h0, c});
    repeat (3) @(posedge pclk);
    chk("gate rdy", 32'(rdy_a), 32'h0);
    chk("gate data", 32'(u_if.data_out), 32'h0);
    ta = -1;
    tb = -1;
    for (int n = 0; n < e_b + 200 && (ta < 0 || tb < 0); n++) begin
      @(posedge pclk);
      if (ta < 0 && rdy_a === 1'b1) ta = n;
      if (tb < 0 && rdy_b === 1'b1) tb = n;
    end
    chk("t433", near(ta, e_a - 3), 32'h1);
    chk("t315", near(tb, e_b - 3), 32'h1);
    if (ta < 0 || tb < 0) begin
      stop_test();
    end
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rf = 2'b00;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl rst", rd, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("stat rst", rd, 32'h0);
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    chk("wr err", 32'(err), 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("rd err", {rd[30:0], err}, 32'h1);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl kept", rd, 32'h0);
    // pin states without activation: off, standby, clock output rates
    foreach (rows[i]) begin
      apb(1'b1, CTRL_OFS, 32'(rows[i].ctrl));
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl", rd, 32'(rows[i].ctrl));
      repeat (450) @(posedge pclk);
      chk("pins", 32'(pins), 32'(rows[i].ctrl));
      chk("osc", 32'(osc_a), 32'(rows[i].osc));
      chk("ready", 32'(rdy_a), 32'h0);
      ta = clk_n;
      repeat (48) @(posedge pclk);
      chk("clk", 32'((clk_n - ta - rows[i].clks) inside {[-1:1]}), 1);
    end
    // start-up from standby, ask, fastest range, carrier present
    rf <= 2'b11;
    change(7'h1f, 22600, 23720);
    rf <= 2'b01;
    repeat (4) @(posedge pclk);
    chk("ask on", 32'({u_if.data_out, u_if2.data_out}), 32'h3);
    rf <= 2'b10;
    repeat (4) @(posedge pclk);
    chk("ask off", 32'({u_if.data_out, u_if2.data_out}), 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("short", 32'(rd[STAT_SHORT_BIT]), 32'h1);
    apb(1'b1, STAT_OFS, 32'h2);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("short clr", 32'(rd[STAT_SHORT_BIT]), 32'h0);
    // range swap in ask, demod plus range, then range swap in fsk
    rf <= 2'b01;
    change(7'h17, 4000, 4000);
    change(7'h0b, 25760, 26600);
    rf <= 2'b10;
    repeat (4) @(posedge pclk);
    chk("fsk hi", 32'(u_if.data_out), 32'h1);
    change(7'h1b, 4000, 4000);
    // fsk range 3: a 30 us spacing is legal, a 20 us one is short
    apb(1'b1, STAT_OFS, 32'h6);
    repeat (1196) @(posedge pclk);
    rf <= 2'b00;
    repeat (8) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("fsk 30us", rd, 32'h0);
    repeat (789) @(posedge pclk);
    rf <= 2'b10;
    repeat (8) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("fsk 20us", rd, 32'h3);
    // demod plus range back to ask range 2, then a 130 us spacing
    change(7'h17, 16680, 17240);
    rf <= 2'b01;
    repeat (8) @(posedge pclk);
    apb(1'b1, STAT_OFS, 32'h6);
    repeat (5189) @(posedge pclk);
    rf <= 2'b00;
    repeat (8) @(posedge pclk);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("long", rd, 32'h4);
    apb(1'b0, SPACE_OFS, 32'h0);
    chk("space", near(rd, 130), 32'h1);
    // leave active, then power down
    apb(1'b1, CTRL_OFS, 32'h1);
    repeat (3) @(posedge pclk);
    chk("stby", 32'({rdy_a, rdy_b, osc_a}), 32'h1);
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (4) @(posedge pclk);
    chk("off", 32'({osc_a, osc_b, u_if.clk_out, u_if2.clk_out,
      u_if2.data_out}), 32'h0);
    // reset in mid start-up
    apb(1'b1, CTRL_OFS, 32'h1f);
    repeat (200) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("rst pins", 32'({pins, osc_a, rdy_a}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl rst2", rd, 32'h0);
    stop_test();
  end
endmodule // rx_mode_startup_and_rate_control_tb_top
`default_nettype wire
